// ==== verif/lineif_far_end.sv ====
// Far-end model: line source, link clocks and terminal rail counters
`timescale 1ns/100ps
module lineif_far_end
(
   // System clock used to time the rail outputs
   input  wire logic       sys_clk,
   // Line and clocks toward the receiver
   output logic      [3:0] tip,
   output logic      [3:0] ring,
   output logic      [3:0] rec_clk,
   output logic      [3:0] ref_clk,
   // Terminal side rails
   input  wire logic [3:0] pos,
   input  wire logic [3:0] neg
);
   int   pos_hi [4];
   int   neg_hi [4];
   int   ref3_half = 40;
   logic ref3;

   // ==============================================================
   // Link clocks
   // Recovered clock runs free; its phase is offset from sys_clk
   initial
   begin
      rec_clk = 4'h0;
      #3;
      forever #40 rec_clk = ~rec_clk;
   end
   // Channel 3 has its own reference source so its rate can drift
   initial
   begin
      ref3 = 1'b0;
      forever #(ref3_half) ref3 = ~ref3;
   end
   // Channels 0 to 2 share the source of the line clock
   assign ref_clk = {ref3, rec_clk[2:0]};

   // ==============================================================
   // Line source
   // Symbols change on the falling edge so the receiver samples mid-bit
   task automatic send(input string s);
      int i;
      for (i = 0; i < 4; i++)
      begin
         pos_hi[i] = 0;
         neg_hi[i] = 0;
      end
      for (i = 0; i < s.len() + 10; i++)
      begin
         @(negedge rec_clk[0]);
         tip  <= (i < s.len() && s[i] == "+") ? 4'hF : 4'h0;
         ring <= (i < s.len() && s[i] == "-") ? 4'hF : 4'h0;
      end
   endtask : send

   // Count high system cycles; one symbol lasts eight of them
   always @(negedge sys_clk)
   begin
      for (int c = 0; c < 4; c++)
      begin
         if (pos[c] === 1'b1) pos_hi[c]++;
         if (neg[c] === 1'b1) neg_hi[c]++;
      end
   end
   initial
   begin
      tip  = 4'h0;
      ring = 4'h0;
   end
endmodule : lineif_far_end

// ==== verif/lineif_rx_output_formatter_bench.sv ====
// Self-checking bench for the four-channel receive output formatter
`timescale 1ns/100ps
`include "lineif_defs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch at %0t: got %0h exp %0h", $time, g, e); end end
module lineif_rx_output_formatter_bench;
   logic        sys_clk;
   logic        reset;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        host_sel;
   logic        rail_sel;
   logic        inv_sel;
   logic        irq;
   logic [3:0]  eq_in;
   logic [3:0]  tip;
   logic [3:0]  ring;
   logic [3:0]  rclk;
   logic [3:0]  refc;
   logic [3:0]  pos;
   logic [3:0]  neg;
   logic [3:0]  clk_out;
   logic [3:0]  eq_on;
   logic [3:0]  lol;
   logic [31:0] rd;
   logic        err;
   int          error_cnt = 0;
   int          cmp_count = 0;

   lineif_rx_output_formatter i_dut (
      .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .host_or_pin_config_select(host_sel),
      .rail_select_or_chip_select(rail_sel),
      .recovered_clock_invert_select(inv_sel),
      .equalizer_enable_in(eq_in), .line_input_tip(tip),
      .line_input_ring(ring), .recovered_clock_in(rclk),
      .reference_clock_in(refc), .rx_positive_rail_out(pos),
      .rx_negative_rail_out(neg), .recovered_clock_out(clk_out),
      .equalizer_on(eq_on), .loss_of_lock(lol), .irq(irq));

   lineif_far_end far (
      .sys_clk(sys_clk), .tip(tip), .ring(ring), .rec_clk(rclk),
      .ref_clk(refc), .pos(pos), .neg(neg));

   // ==============================================================
   // Tasks
   // One APB transfer; the request holds until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Mode pins change on the clock, then the synchronisers settle
   task automatic pins(input logic h, input logic r, input logic i,
                       input logic [3:0] e);
      @(posedge sys_clk);
      host_sel <= h;
      rail_sel <= r;
      inv_sel  <= i;
      eq_in    <= e;
      repeat (10) @(posedge sys_clk);
   endtask : pins

   // Output clock sampled six system cycles after the line clock rises, late in its delayed high phase
   task automatic clk_chk(input logic [3:0] e);
      @(posedge rclk[0]);
      repeat (6) @(posedge sys_clk);
      `CHK(clk_out, e)
   endtask : clk_chk

   // Drive a pattern, compare symbol counts on both rails per channel
   task automatic line_chk(input string s, input int p[4], input int n[4]);
      far.send(s);
      for (int c = 0; c < 4; c++)
      begin
         `CHK((far.pos_hi[c] + 4) / 8, p[c])
         `CHK((far.neg_hi[c] + 4) / 8, n[c])
      end
   endtask : line_chk

   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   // ==============================================================
   // Clock and watchdog
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Whole run is near 40 us; five times that means a hang
   initial
   begin
      #200us;
      error_cnt++;
      end_of_test();
   end

   // ==============================================================
   // Main sequence
   initial
   begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      host_sel = 1'b0;
      rail_sel = 1'b0;
      inv_sel = 1'b1;
      eq_in = 4'h0;
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      // Register map: reset values, write mask, unmapped place
      apb(1'b0, `ADDR_CONTROL, 32'h0);
      `CHK(rd, 32'h0000_0010)
      apb(1'b0, `ADDR_INT_MASK, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, `ADDR_CONTROL, 32'hFFFF_FFFF);
      apb(1'b0, `ADDR_CONTROL, 32'h0);
      `CHK(rd, `CONTROL_MASK)
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      `CHK(err, 1'b1)
      apb(1'b0, 12'h010, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, `ADDR_CONTROL, `CONTROL_RESET);
      // Pin mode, dual rail, invert pin high as if left open
      pins(1'b0, 1'b0, 1'b1, 4'h0);
      clk_chk(4'h0);
      line_chk("+-0+-", '{2, 2, 2, 2}, '{2, 2, 2, 2});
      // Pin mode, single rail: substitution removed, bare violation flagged
      pins(1'b0, 1'b1, 1'b1, 4'h6);
      line_chk("+-00-+-++", '{6, 6, 6, 6}, '{1, 1, 1, 1});
      `CHK(eq_on, 4'h6)
      // Interrupt raised, masked and cleared by reading
      `CHK(irq, 1'b0)
      apb(1'b1, `ADDR_INT_MASK, 32'h0F);
      repeat (3) @(posedge sys_clk);
      `CHK(irq, 1'b1)
      apb(1'b0, `ADDR_INT_STATUS, 32'h0);
      `CHK(rd, 32'h0000_000F)
      repeat (3) @(posedge sys_clk);
      `CHK(irq, 1'b0)
      // Host mode: rail and code bits per channel, register invert, equalizer
      pins(1'b1, 1'b0, 1'b1, 4'h5);
      apb(1'b1, `ADDR_CONTROL, 32'h0000_1A05);
      repeat (5) @(posedge sys_clk);
      `CHK(eq_on, 4'hA)
      clk_chk(4'hF);
      line_chk("-+00+-+--", '{5, 3, 6, 3}, '{1, 4, 1, 4});
      // Pin mode, invert pin low acts on every channel
      pins(1'b0, 1'b0, 1'b0, 4'h9);
      `CHK(eq_on, 4'h9)
      clk_chk(4'hF);
      // Channel 3 reference drifts to half rate: only its lock fails
      apb(1'b1, `ADDR_INT_MASK, 32'hF0);
      far.ref3_half = 80;
      repeat (3000) @(posedge sys_clk);
      `CHK(lol, 4'h8)
      `CHK(irq, 1'b1)
      apb(1'b0, `ADDR_INT_STATUS, 32'h0);
      `CHK(rd[7:4], 4'h8)
      `CHK({rd[2], rd[0]}, 2'b11)
      end_of_test();
   end
endmodule : lineif_rx_output_formatter_bench

// ==== verilog/lineif_channel.sv ====
// One receive channel: sampling, zero-substitution decode, lock monitor
`timescale 1ns/100ps
`include "lineif_defs.svh"
module lineif_channel
   import lineif_pkg::*;
(
   // Clock and reset
   input  wire logic    sys_clk,
   input  wire logic    reset,
   // Configuration
   input  wire ch_cfg_t cfg,
   // Line side pins
   input  wire logic    tip,
   input  wire logic    ring,
   input  wire logic    rec_clk,
   input  wire logic    ref_clk,
   // Results
   output ch_out_t      out
);

   chan_state_t st;
   chan_state_t next_st;
   logic [3:0]  s;
   logic        rise, fall, out_edge, p_in, n_in, bpv;
   logic        z1, z2, z3, sub00, subb, is_sub, ref_rise;
   sym_t        tail;

   // ===============================================================
   // Pin synchronisers
   lineif_sync #(.W(4)) u_sync
   (
      .sys_clk (sys_clk),
      .reset   (reset),
      .d       ({tip, ring, rec_clk, ref_clk}),
      .q       (s)
   );

   // ===============================================================
   // Next-state logic
   always_comb
   begin
      next_st  = st;
      rise     = s[1] & ~st.clk_d;
      fall     = ~s[1] & st.clk_d;
      out_edge = cfg.invert ? fall : rise;               // R10
      p_in     = s[3] & ~s[2];
      n_in     = s[2] & ~s[3];
      bpv      = (p_in | n_in) && st.seen && (n_in == st.last_neg);
      z1 = ~(st.pipe[0].pos | st.pipe[0].neg);
      z2 = ~(st.pipe[1].pos | st.pipe[1].neg);
      z3 = ~(st.pipe[2].pos | st.pipe[2].neg);
      // Substitution shapes differ by code: three or four symbols long
      if (cfg.hdb3)
      begin
         sub00 = z1 & z2 & z3;
         subb  = z1 & z2 & ~z3 & (st.pipe[2].neg == n_in);
      end
      else
      begin
         sub00 = z1 & z2;
         subb  = z1 & ~z2 & (st.pipe[1].neg == n_in);
      end
      is_sub   = cfg.single_rail & bpv & (sub00 | subb);  // R6
      tail     = st.pipe[3];
      ref_rise = s[0] & ~st.ref_d;
      next_st.clk_d    = s[1];
      next_st.ref_d    = s[0];
      next_st.viol_evt = 1'b0;
      next_st.clk_o    = s[1] ^ cfg.invert;               // R9
      // Shift a symbol in on each recovered rising edge
      if (rise)
      begin
         if (is_sub && subb && cfg.hdb3)
            next_st.pipe[2] = '0;                         // R6
         else if (is_sub && subb)
            next_st.pipe[1] = '0;                         // R6
         next_st.pipe[3:1] = next_st.pipe[2:0];
         next_st.pipe[0].pos  = p_in & ~is_sub;           // R2
         next_st.pipe[0].neg  = n_in & ~is_sub;           // R1
         next_st.pipe[0].viol = cfg.single_rail & bpv & ~is_sub; // R17
         if (p_in | n_in)
         begin
            next_st.last_neg = n_in;
            next_st.seen     = 1'b1;
         end
         if (st.rec_cnt != 7'h7F)
            next_st.rec_cnt = st.rec_cnt + 7'h01;
      end
      // Rails change only on the selected recovered edge
      if (out_edge)
      begin
         if (cfg.single_rail)
         begin
            next_st.pos_o    = tail.pos | tail.neg;       // R4
            next_st.neg_o    = tail.viol;                 // R3
            next_st.viol_evt = tail.viol;                 // R17
         end
         else
         begin
            next_st.pos_o = tail.pos;                     // R2
            next_st.neg_o = tail.neg;                     // R1
         end
      end
      // Compare recovered edges against a window of reference edges
      if (ref_rise)
      begin
         next_st.ref_cnt = st.ref_cnt + 7'h01;
         if (st.ref_cnt == `LOL_WINDOW - 7'h01)
         begin
            next_st.lol = (st.rec_cnt > `LOL_WINDOW + `LOL_TOLERANCE)
               || (st.rec_cnt + `LOL_TOLERANCE < `LOL_WINDOW); // R13
            next_st.ref_cnt = '0;
            next_st.rec_cnt = '0;
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   assign out = '{pos: st.pos_o, neg: st.neg_o, clk: st.clk_o,
                  lol: st.lol, viol_evt: st.viol_evt};

   // ===============================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   AST_DUAL_NEG: assert property (out_edge && !cfg.single_rail |=> // R1
      st.neg_o == $past(st.pipe[3].neg)) else $error("neg rail wrong");
   AST_DUAL_POS: assert property (out_edge && !cfg.single_rail |=> // R2
      st.pos_o == $past(st.pipe[3].pos)) else $error("pos rail wrong");
   AST_SR_VIOL: assert property (out_edge && cfg.single_rail |=> // R3
      st.neg_o == $past(st.pipe[3].viol)) else $error("lcv wrong");
   AST_SR_DATA: assert property (out_edge && cfg.single_rail |=> // R4
      st.pos_o == $past(st.pipe[3].pos | st.pipe[3].neg))
      else $error("single rail data wrong");
   AST_SUB_ZERO: assert property (rise && is_sub |=> // R6
      !st.pipe[0].pos && !st.pipe[0].neg) else $error("V not removed");
   AST_HOLD: assert property (!out_edge |=> // R10
      $stable({st.pos_o, st.neg_o})) else $error("rail moved off edge");
   AST_CLK_INV: assert property (##1 1'b1 |-> // R9
      st.clk_o == ($past(s[1]) ^ $past(cfg.invert)))
      else $error("clock invert wrong");
   AST_LOL_DEAD: assert property (ref_rise && // R13
      st.ref_cnt == `LOL_WINDOW - 7'h01 && st.rec_cnt == 7'h00 |=>
      st.lol) else $error("lol not declared");

   COV_SUB: cover property (rise && is_sub);
   COV_VIOL: cover property (st.viol_evt);

endmodule : lineif_channel

// ==== verilog/lineif_defs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef LINEIF_DEFS_SVH
`define LINEIF_DEFS_SVH

// ==================================================================
// Register byte offsets
`define ADDR_CONTROL     12'h000
`define ADDR_STATUS      12'h004
`define ADDR_INT_STATUS  12'h008
`define ADDR_INT_MASK    12'h00C

// ==================================================================
// Control fields
`define CTL_RAIL_LSB     0
`define CTL_INVERT       4
`define CTL_EQ_LSB       8
`define CTL_E3_LSB       12
`define CONTROL_RESET    32'h0000_0010
`define CONTROL_MASK     32'h0000_FF1F

// ==================================================================
// Interrupt status fields
`define INT_LCV_LSB      0
`define INT_LOL_LSB      4
`define INT_MASK_BITS    8'hFF

// ==================================================================
// Lock monitor: window in reference edges and allowed slip
`define LOL_WINDOW       7'h40
`define LOL_TOLERANCE    7'h04

`endif

// ==== verilog/lineif_pkg.sv ====
// Types shared by the receive output formatter and its channels
package lineif_pkg;

   // ===============================================================
   // Per-channel configuration, already resolved for host/pin mode
   typedef struct packed {
      logic single_rail;
      logic hdb3;
      logic invert;
   } ch_cfg_t;

   // Per-channel outputs
   typedef struct packed {
      logic pos;
      logic neg;
      logic clk;
      logic lol;
      logic viol_evt;
   } ch_out_t;

   // One received symbol in the decode pipeline
   typedef struct packed {
      logic pos;
      logic neg;
      logic viol;
   } sym_t;

   // Whole state of one channel
   typedef struct packed {
      sym_t [3:0] pipe;
      logic       last_neg;
      logic       seen;
      logic       clk_d;
      logic       ref_d;
      logic [6:0] ref_cnt;
      logic [6:0] rec_cnt;
      logic       lol;
      logic       pos_o;
      logic       neg_o;
      logic       clk_o;
      logic       viol_evt;
   } chan_state_t;

   // Whole state of the top level
   typedef struct packed {
      logic [31:0] control;
      logic [7:0]  int_stat;
      logic [7:0]  int_mask;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic [3:0]  lol_d;
      logic [3:0]  eq_out;
   } top_state_t;

endpackage : lineif_pkg

// ==== verilog/lineif_rx_output_formatter.sv ====
// Four-channel receive output formatter with APB registers
//
// Summary of operation
// R1 - Dual rail: negative rail pulses high for each negative line pulse.
// R2 - Dual rail: positive rail pulses high for each positive line pulse.
// R3 - Pin mode, rail select high: decoder on, violation flag on rail.
// R4 - Single rail: decoded data leaves on the positive rail only.
// R5 - Host mode: per-channel bit, 0 dual rail, 1 single rail.
// R6 - Decoder on: substitution codes become zeros on the data outputs.
// R7 - Pin mode: equalizer enable follows each channel's enable input.
// R8 - Host mode: equalizer enable pins ignored; keep them grounded.
// R9 - Pin mode: one invert select inverts every recovered clock.
// R10 - Invert low: rails change on rising edge; high: on falling edge.
// R11 - Invert select open counts as high: falling edge by default.
// R12 - Far end supplies each reference clock at that channel's rate.
// R13 - Loss of lock compares recovered clock against reference clock.
// R14 - Far end may share reference and transmit clock sources.
// R15 - Each channel runs at its own rate independently.
// R16 - Pin mode: rail select sets all four channels together.
// R17 - Each violation outside a substitution flags one recovered period.
`timescale 1ns/100ps
`include "lineif_defs.svh"
module lineif_rx_output_formatter
   import lineif_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Mode and configuration pins
   input  wire logic        host_or_pin_config_select,
   input  wire logic        rail_select_or_chip_select,
   input  wire logic        recovered_clock_invert_select,
   input  wire logic [3:0]  equalizer_enable_in,
   // Line side, per channel
   input  wire logic [3:0]  line_input_tip,
   input  wire logic [3:0]  line_input_ring,
   input  wire logic [3:0]  recovered_clock_in,
   input  wire logic [3:0]  reference_clock_in,
   // Terminal side, per channel
   output logic      [3:0]  rx_positive_rail_out,
   output logic      [3:0]  rx_negative_rail_out,
   output logic      [3:0]  recovered_clock_out,
   // Analog control and alarms
   output logic      [3:0]  equalizer_on,
   output logic      [3:0]  loss_of_lock,
   // Interrupt
   output logic             irq
);

   top_state_t  st;
   top_state_t  next_st;
   logic [6:0]  pins_s;
   logic        host_s;
   logic        rail_s;
   logic        inv_s;
   logic [3:0]  eq_s;
   logic [3:0]  rail_eff;
   logic        inv_eff;
   logic [3:0]  eq_eff;
   ch_cfg_t     cfg [4];
   ch_out_t     ch_out [4];
   logic [3:0]  viol_evt;
   logic [3:0]  lol_now;
   logic        setup;
   logic        access;
   logic        mapped;
   logic [31:0] rd_val;
   logic [7:0]  int_set;
   logic [7:0]  int_clr;

   // ===============================================================
   // Static pins cross into the system clock domain
   lineif_sync #(.W(7)) u_pin_sync
   (
      .sys_clk (sys_clk),
      .reset   (reset),
      .d       ({host_or_pin_config_select, rail_select_or_chip_select,
                 recovered_clock_invert_select, equalizer_enable_in}),
      .q       (pins_s)
   );

   assign host_s = pins_s[6];
   assign rail_s = pins_s[5];
   assign inv_s  = pins_s[4];
   assign eq_s   = pins_s[3:0];

   // ===============================================================
   // Mode resolution: host register or pins
   // An open invert pin is pulled high on the pad, and the host bit
   // resets to one, so both modes default to the falling edge.
   always_comb
   begin
      if (host_s)
      begin
         rail_eff = st.control[`CTL_RAIL_LSB +: 4];      // R5
         inv_eff  = st.control[`CTL_INVERT];              // R11
         eq_eff   = st.control[`CTL_EQ_LSB +: 4];         // R8
      end
      else
      begin
         rail_eff = {4{rail_s}};                          // R16
         inv_eff  = inv_s;                                // R11
         eq_eff   = eq_s;                                 // R7
      end
   end

   // ===============================================================
   // Channels, each with its own rate and decode type
   genvar n;
   generate
      for (n = 0; n < 4; n++)
      begin : g_ch
         assign cfg[n] = '{single_rail: rail_eff[n],          // R3
                           hdb3: st.control[`CTL_E3_LSB + n], // R15
                           invert: inv_eff};                  // R9

         lineif_channel u_ch
         (
            .sys_clk (sys_clk),
            .reset   (reset),
            .cfg     (cfg[n]),
            .tip     (line_input_tip[n]),
            .ring    (line_input_ring[n]),
            .rec_clk (recovered_clock_in[n]),
            .ref_clk (reference_clock_in[n]),
            .out     (ch_out[n])
         );

         assign rx_positive_rail_out[n] = ch_out[n].pos;
         assign rx_negative_rail_out[n] = ch_out[n].neg;
         assign recovered_clock_out[n]  = ch_out[n].clk;
         assign loss_of_lock[n]         = ch_out[n].lol;
         assign viol_evt[n]             = ch_out[n].viol_evt;
         assign lol_now[n]              = ch_out[n].lol;
      end
   endgenerate

   // ===============================================================
   // APB decode
   assign setup  = psel & ~penable;
   assign access = psel & penable & st.pready;

   // Read data is captured in the setup cycle so it leaves a flop
   always_comb
   begin
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      case (paddr)
         `ADDR_CONTROL:    rd_val = st.control;
         `ADDR_STATUS:     rd_val = {16'h0000, eq_eff, rail_eff,
                                     2'b00, inv_eff, host_s, lol_now};
         `ADDR_INT_STATUS: rd_val = {24'h00_0000, st.int_stat};
         `ADDR_INT_MASK:   rd_val = {24'h00_0000, st.int_mask};
         default:          mapped = 1'b0;
      endcase
   end

   // ===============================================================
   // Sticky events and read-to-clear
   // Only the bits actually returned are cleared, and a new event in
   // the clearing cycle is kept: the set wins.
   always_comb
   begin
      int_set = {lol_now & ~st.lol_d, viol_evt};
      int_clr = 8'h00;
      if (access && !pwrite && paddr == `ADDR_INT_STATUS)
         int_clr = st.prdata[7:0];
   end

   // ===============================================================
   // Next-state logic
   always_comb
   begin
      next_st          = st;
      next_st.pready   = setup;
      next_st.lol_d    = lol_now;
      next_st.eq_out   = eq_eff;                          // R7
      next_st.int_stat = (st.int_stat & ~int_clr) | int_set;
      if (setup)
      begin
         next_st.pslverr = ~mapped;
         next_st.prdata  = pwrite ? 32'h0000_0000 : rd_val;
      end
      else if (access)
      begin
         next_st.pslverr = 1'b0;
      end
      // Writes land at the access edge only
      if (access && pwrite)
      begin
         case (paddr)
            `ADDR_CONTROL:  next_st.control = pwdata & `CONTROL_MASK;
            `ADDR_INT_MASK: next_st.int_mask = pwdata[7:0]
                                               & `INT_MASK_BITS;
            default:        next_st.control = st.control;
         endcase
      end
      next_st.irq = |(next_st.int_stat & next_st.int_mask);
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         st         <= '0;
         st.control <= `CONTROL_RESET;                    // R11
      end
      else
         st <= next_st;
   end

   // ===============================================================
   // Outputs, all from the state register
   assign prdata       = st.prdata;
   assign pready       = st.pready;
   assign pslverr      = st.pslverr;
   assign irq          = st.irq;
   assign equalizer_on = st.eq_out;

   // ===============================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   AST_HOST_RAIL: assert property (host_s |-> // R5
      rail_eff == st.control[3:0]) else $error("host rail select wrong");
   AST_HW_RAIL: assert property (!host_s |-> // R16
      rail_eff == {4{rail_s}}) else $error("pin rail select wrong");
   AST_HW_EQ: assert property (!host_s ##1 !host_s |-> // R7
      equalizer_on == $past(eq_s)) else $error("eq not following pin");
   AST_HOST_EQ: assert property (host_s ##1 host_s |-> // R8
      equalizer_on == $past(st.control[11:8]))
      else $error("eq pin not ignored");
   AST_HW_INV: assert property (!host_s |-> // R9
      cfg[0].invert == inv_s && cfg[3].invert == inv_s)
      else $error("invert not common");
   AST_RESET_INV: assert property ($fell(reset) |-> // R11
      st.control[4]) else $error("invert default not high");
   AST_READY: assert property (setup |=> pready ##1 !pready)
      else $error("pready timing wrong");
   AST_IRQ: assert property (irq == |(st.int_stat & st.int_mask))
      else $error("irq mismatch");
   AST_LCV_STICKY: assert property (viol_evt[0] |=> // R17
      st.int_stat[0]) else $error("violation event lost");

   // Bus answers: error only for an unmapped place
   AST_SLVERR: assert property (setup |=>
      pready && pslverr == !$past(mapped))
      else $error("slave error wrong");

   // Writes land at once, less the bits that do not exist
   AST_CTRL_WR: assert property (access && pwrite &&
      paddr == `ADDR_CONTROL |=>
      st.control == ($past(pwdata) & `CONTROL_MASK))
      else $error("control write lost");
   AST_MASK_WR: assert property (access && pwrite &&
      paddr == `ADDR_INT_MASK |=> st.int_mask == $past(pwdata[7:0]))
      else $error("mask write lost");

   // Reads leave the configuration alone
   AST_RD_QUIET: assert property (access && !pwrite |=>
      $stable(st.control) && $stable(st.int_mask))
      else $error("read changed a register");

   // Read clear drops just the returned bits when nothing new arrives
   AST_RDCLR: assert property (access && !pwrite &&
      paddr == `ADDR_INT_STATUS && int_set == 8'h00 |=>
      st.int_stat == ($past(st.int_stat) & ~$past(st.prdata[7:0])))
      else $error("status not cleared");

   // A new loss of lock always leaves its sticky bit
   AST_LOL_STICKY: assert property (lol_now[3] && !st.lol_d[3] |=> // R13
      st.int_stat[7]) else $error("lock loss event lost");

   // Pin mode: one rail select for every channel
   AST_HW_SR: assert property (!host_s |-> // R16
      cfg[1].single_rail == rail_s && cfg[2].single_rail == rail_s)
      else $error("rail select not common");

   // Each channel keeps its own line code select
   AST_OWN_CODE: assert property (cfg[1].hdb3 == st.control[13] && // R15
      cfg[2].hdb3 == st.control[14]) else $error("code select crossed");

   // Nothing interrupts while every source is masked
   AST_IRQ_MASKED: assert property (st.int_mask == 8'h00 |-> !irq)
      else $error("irq while all masked");

   COV_IRQ: cover property ($rose(irq));
   COV_RDCLR: cover property (|int_clr);
   COV_LOL: cover property ($rose(loss_of_lock[0]));

endmodule : lineif_rx_output_formatter

// ==== verilog/lineif_sync.sv ====
// Two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/100ps
module lineif_sync #(parameter int W = 1)
(
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         reset,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : lineif_sync
